// file: pkg/fcs_pkg.sv
// constants, types and rate table for the clock setup block
package fcs_pkg;
	// register subaddresses
	localparam logic [15:0] ADDR_CLK_SEL = 16'h4000;
	localparam logic [15:0] ADDR_PLL0 = 16'h4002;
	localparam logic [15:0] PLL_BYTES = 16'h0006;
	localparam logic [15:0] ADDR_CONV = 16'h4017;
	localparam logic [15:0] ADDR_ENG = 16'h40eb;
	localparam logic [15:0] ADDR_SER = 16'h40f8;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// clock select fields
	localparam int CS_EN_BIT = 0;
	localparam int CS_DIV_LSB = 1;
	localparam int CS_SRC_BIT = 3;
	localparam int CS_MIC_BIT = 4;
	// pll parameter fields, bit positions within the 48-bit value
	localparam int PLL_M_LSB = 0;
	localparam int PLL_N_LSB = 16;
	localparam int PLL_FRAC_BIT = 32;
	localparam int PLL_X_BIT = 33;
	localparam int PLL_R_LSB = 35;
	localparam int PLL_EN_BIT = 40;
	localparam int PLL_LOCK_BIT = 41;
	localparam logic [2:0] PLL_LAST_IDX = 3'h5;
	// pll output runs at four times the core clock
	localparam int CORE_SHIFT = 2;
	// timing
	localparam int SYS_CLK_MHZ = 40;
	localparam int REF_MIN_MHZ = 11;
	localparam int REF_MAX_MHZ = 20;
	localparam logic [3:0] REF_PER_MIN_CYC = 4'(SYS_CLK_MHZ / REF_MAX_MHZ);
	localparam logic [3:0] REF_PER_MAX_CYC = 4'((SYS_CLK_MHZ + REF_MIN_MHZ - 1) / REF_MIN_MHZ);
	localparam int LOCK_REF_EDGES = 1024;
	// frame lengths in core clock cycles, divider times 256
	localparam logic [10:0] FRAME_X1 = 11'h100;
	localparam logic [10:0] FRAME_X6 = 11'h600;
	localparam logic [10:0] FRAME_X4 = 11'h400;
	localparam logic [10:0] FRAME_X3 = 11'h300;
	localparam logic [10:0] FRAME_X2 = 11'h200;
	localparam logic [10:0] FRAME_X1P5 = 11'h180;
	localparam logic [10:0] FRAME_X0P5 = 11'h080;

	typedef enum logic [1:0] {
		PLL_OFF = 2'b00,
		PLL_ACQ = 2'b01,
		PLL_LOCK = 2'b11
	} fcs_pll_st_t;

	function automatic logic [10:0] frame_cycles(input logic [3:0] code);
		case (code)
			4'h0: frame_cycles = FRAME_X1;
			4'h1: frame_cycles = FRAME_X6;
			4'h2: frame_cycles = FRAME_X4;
			4'h3: frame_cycles = FRAME_X3;
			4'h4: frame_cycles = FRAME_X2;
			4'h5: frame_cycles = FRAME_X1P5;
			4'h6: frame_cycles = FRAME_X0P5;
			default: frame_cycles = FRAME_X1;
		endcase
	endfunction : frame_cycles
endpackage : fcs_pkg

// file: logic/fcs_rate_div.sv
// frame strobe divider counting core clock ticks
`timescale 1ns/1ps
`default_nettype none
module fcs_rate_div #(
	parameter int SEL_W = 3
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic tick_i,
	input wire logic enable_i,
	input wire logic [SEL_W-1:0] sel_i,
	output logic frame_o
);
	typedef struct packed {
		logic [10:0] cnt;
		logic frame;
	} fcs_div_st_t;

	fcs_div_st_t s;
	fcs_div_st_t n;

	always_comb begin
		logic [10:0] period;
		period = fcs_pkg::frame_cycles(4'(sel_i)); // RQ10
		n = s;
		n.frame = 1'b0;
		if (!enable_i) begin
			n.cnt = '0;
		end else if (tick_i) begin
			if (s.cnt >= period - 11'h001) begin
				n.cnt = '0;
				n.frame = 1'b1; // RQ10
			end else begin
				n.cnt = s.cnt + 11'h001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign frame_o = s.frame;
endmodule : fcs_rate_div
`default_nettype wire

// file: logic/fcs_clock_setup.sv
// core clock generation, pll model, rate selection and mic clock
// What this block does
// [RQ1] pll references master clock, 11 to 20 MHz
// [RQ2] host writes six pll bytes in one burst
// [RQ3] host picks integer or fractional mode
// [RQ4] integer mode multiplies reference by integer field
// [RQ5] integer mode ignores numerator and denominator
// [RQ6] fractional mode multiplies by integer plus fraction
// [RQ7] host keeps pll output within 41-54 MHz
// [RQ8] converter rate from 3-bit field
// [RQ9] engine 4-bit and serial 3-bit rate fields
// [RQ10] frame spans divider times 256 core cycles
// [RQ11] mic clock rate set in clock select
// [RQ12] pll source divides output by four
// [RQ13] source bit: 0 pin direct, 1 pll
// [RQ14] reference divided by input divider first
// [RQ15] host waits for lock before enabling core
`timescale 1ns/1ps
`default_nettype none
module fcs_clock_setup #(
	parameter int LOCK_REF_EDGES = fcs_pkg::LOCK_REF_EDGES
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic REFERENCE_CLOCK_PIN_I,
	input wire logic [15:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic REG_STOP_I,
	output logic [7:0] REG_RDATA_O,
	output logic CORE_TICK_O,
	output logic PLL_LOCK_O,
	output logic MIC_CLOCK_OUT_O,
	output logic CONV_FRAME_O,
	output logic ENGINE_FRAME_O,
	output logic SERIAL_FRAME_O
);
	typedef struct packed {
		logic [7:0] clk_sel;
		logic [7:0] conv;
		logic [7:0] eng;
		logic [7:0] ser;
		logic [47:0] pll_cfg;
		logic [47:0] pll_sh;
		logic [2:0] pll_idx;
		logic [7:0] rdata;
		logic ref_q;
		logic [2:0] per_cnt;
		logic ref_ok;
		fcs_pkg::fcs_pll_st_t st;
		logic [15:0] lock_cnt;
		logic [21:0] acc;
		logic [1:0] ddiv;
		logic core_tick;
		logic mic_cnt;
		logic mic_clk;
	} fcs_st_t;

	fcs_st_t s;
	fcs_st_t n;

	always_comb begin
		logic ref_edge;
		logic [3:0] per;
		logic [15:0] pidx;
		logic [15:0] m_eff;
		logic [3:0] r_f;
		logic frac;
		logic xdiv2;
		logic [20:0] rm;
		logic [20:0] k;
		logic [21:0] t_base;
		logic [21:0] t;
		logic [21:0] sum;
		logic [7:0] pbyte;
		k = '0;
		t_base = '0;
		ref_edge = REFERENCE_CLOCK_PIN_I & ~s.ref_q;
		per = {1'b0, s.per_cnt} + 4'h1;
		pidx = REG_ADDR_I - fcs_pkg::ADDR_PLL0;
		m_eff = s.pll_cfg[fcs_pkg::PLL_M_LSB +: 16];
		if (m_eff == 16'h0000) begin
			m_eff = 16'h0001;
		end
		r_f = s.pll_cfg[fcs_pkg::PLL_R_LSB +: 4];
		frac = s.pll_cfg[fcs_pkg::PLL_FRAC_BIT];
		xdiv2 = s.pll_cfg[fcs_pkg::PLL_X_BIT];
		rm = 21'(r_f) * 21'(m_eff);
		pbyte = s.pll_cfg[8*pidx[2:0] +: 8];
		n = s;
		n.core_tick = 1'b0;
		n.ref_q = REFERENCE_CLOCK_PIN_I;

		// reference period check, 2 to 4 system cycles per edge
		if (ref_edge) begin
			n.per_cnt = '0;
			n.ref_ok = (per >= fcs_pkg::REF_PER_MIN_CYC) && (per <= fcs_pkg::REF_PER_MAX_CYC); // RQ1
		end else begin
			if (s.per_cnt != 3'h7) begin
				n.per_cnt = s.per_cnt + 3'h1;
			end
			if (per > fcs_pkg::REF_PER_MAX_CYC) begin
				n.ref_ok = 1'b0; // RQ1
			end
		end

		// register reads
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				fcs_pkg::ADDR_CLK_SEL: n.rdata = s.clk_sel;
				fcs_pkg::ADDR_CONV: n.rdata = s.conv;
				fcs_pkg::ADDR_ENG: n.rdata = s.eng;
				fcs_pkg::ADDR_SER: n.rdata = s.ser;
				default: begin
					n.rdata = 8'h00;
					if (REG_ADDR_I >= fcs_pkg::ADDR_PLL0 && pidx < fcs_pkg::PLL_BYTES) begin
						n.rdata = pbyte;
						if (pidx[2:0] == fcs_pkg::PLL_LAST_IDX) begin
							n.rdata[fcs_pkg::PLL_LOCK_BIT - 40] = (s.st == fcs_pkg::PLL_LOCK);
						end
					end
				end
			endcase
		end

		// pll state
		unique case (s.st)
			fcs_pkg::PLL_OFF: begin
				n.lock_cnt = '0;
				if (s.pll_cfg[fcs_pkg::PLL_EN_BIT]) begin
					n.st = fcs_pkg::PLL_ACQ;
				end
			end
			fcs_pkg::PLL_ACQ: begin
				if (!s.pll_cfg[fcs_pkg::PLL_EN_BIT]) begin
					n.st = fcs_pkg::PLL_OFF;
				end else if (!s.ref_ok) begin
					n.lock_cnt = '0;
				end else if (ref_edge) begin
					if (s.lock_cnt == 16'(LOCK_REF_EDGES - 1)) begin
						n.st = fcs_pkg::PLL_LOCK;
					end else begin
						n.lock_cnt = s.lock_cnt + 16'h0001;
					end
				end
			end
			fcs_pkg::PLL_LOCK: begin
				n.lock_cnt = '0;
				if (!s.pll_cfg[fcs_pkg::PLL_EN_BIT]) begin
					n.st = fcs_pkg::PLL_OFF;
				end else if (!s.ref_ok) begin
					n.st = fcs_pkg::PLL_ACQ;
				end
			end
			default: begin
				n.st = fcs_pkg::PLL_OFF;
			end
		endcase

		// register writes; pll bytes only in one ascending burst from the first
		if (REG_WR_I) begin
			n.pll_idx = 3'h0;
			case (REG_ADDR_I)
				fcs_pkg::ADDR_CLK_SEL: n.clk_sel = REG_WDATA_I;
				fcs_pkg::ADDR_CONV: n.conv = REG_WDATA_I;
				fcs_pkg::ADDR_ENG: n.eng = REG_WDATA_I;
				fcs_pkg::ADDR_SER: n.ser = REG_WDATA_I;
				fcs_pkg::ADDR_PLL0: begin
					n.pll_sh[7:0] = REG_WDATA_I; // RQ2
					n.pll_idx = 3'h1;
				end
				default: begin
					if (s.pll_idx != 3'h0 && pidx == {13'h0000, s.pll_idx}) begin
						n.pll_sh[8*s.pll_idx +: 8] = REG_WDATA_I; // RQ2
						if (s.pll_idx == fcs_pkg::PLL_LAST_IDX) begin
							n.pll_cfg = {REG_WDATA_I, s.pll_sh[39:0]}; // RQ2
							n.st = fcs_pkg::PLL_OFF;
							n.lock_cnt = '0;
							n.acc = '0;
						end else begin
							n.pll_idx = s.pll_idx + 3'h1;
						end
					end
				end
			endcase
		end
		if (REG_STOP_I) begin
			n.pll_idx = 3'h0; // RQ2
		end

		// pll ratio: per reference edge add k, one core tick per t
		if (frac) begin
			k = rm + 21'(s.pll_cfg[fcs_pkg::PLL_N_LSB +: 16]); // RQ6
			t_base = 22'(m_eff); // RQ6
		end else begin
			k = 21'(r_f); // RQ4 RQ5
			t_base = 22'h00_0001; // RQ5
		end
		t = t_base << (fcs_pkg::CORE_SHIFT + int'(xdiv2)); // RQ12 RQ14
		sum = s.acc + (ref_edge ? {1'b0, k} : 22'h00_0000);

		// core clock
		if (!s.clk_sel[fcs_pkg::CS_EN_BIT]) begin
			n.acc = '0;
			n.ddiv = '0;
		end else if (s.clk_sel[fcs_pkg::CS_SRC_BIT]) begin // RQ13
			n.ddiv = '0;
			if (s.st == fcs_pkg::PLL_LOCK) begin
				if (sum >= t) begin
					n.core_tick = 1'b1; // RQ4 RQ6 RQ12
					sum = sum - t;
				end
				n.acc = sum;
			end else begin
				n.acc = '0;
			end
		end else begin
			n.acc = '0;
			if (ref_edge) begin
				if (s.ddiv == s.clk_sel[fcs_pkg::CS_DIV_LSB +: 2]) begin
					n.ddiv = '0;
					n.core_tick = 1'b1; // RQ13
				end else begin
					n.ddiv = s.ddiv + 2'h1;
				end
			end
		end

		// mic clock: core/2 or core/4
		if (!s.clk_sel[fcs_pkg::CS_EN_BIT]) begin
			n.mic_clk = 1'b0;
			n.mic_cnt = 1'b0;
		end else if (n.core_tick) begin
			n.mic_cnt = ~s.mic_cnt;
			if (s.clk_sel[fcs_pkg::CS_MIC_BIT] || s.mic_cnt) begin
				n.mic_clk = ~s.mic_clk; // RQ11
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	fcs_rate_div #(.SEL_W(3)) u_conv_div (
		.clk_i(SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.tick_i(s.core_tick),
		.enable_i(s.clk_sel[fcs_pkg::CS_EN_BIT]),
		.sel_i(s.conv[2:0]), // RQ8
		.frame_o(CONV_FRAME_O)
	);

	fcs_rate_div #(.SEL_W(4)) u_eng_div (
		.clk_i(SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.tick_i(s.core_tick),
		.enable_i(s.clk_sel[fcs_pkg::CS_EN_BIT]),
		.sel_i(s.eng[3:0]), // RQ9
		.frame_o(ENGINE_FRAME_O)
	);

	fcs_rate_div #(.SEL_W(3)) u_ser_div (
		.clk_i(SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.tick_i(s.core_tick),
		.enable_i(s.clk_sel[fcs_pkg::CS_EN_BIT]),
		.sel_i(s.ser[2:0]), // RQ9
		.frame_o(SERIAL_FRAME_O)
	);

	assign REG_RDATA_O = s.rdata;
	assign CORE_TICK_O = s.core_tick;
	assign PLL_LOCK_O = (s.st == fcs_pkg::PLL_LOCK);
	assign MIC_CLOCK_OUT_O = s.mic_clk;
endmodule : fcs_clock_setup
`default_nettype wire

// file: bench/fcs_clock_setup_sva.sv
// assertion checker for the clock setup block
`timescale 1ns/1ps
`default_nettype none
module fcs_clock_setup_sva #(
	parameter int LOCK_REF_EDGES = 1024
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic REFERENCE_CLOCK_PIN_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_RDATA_O,
	input wire logic CORE_TICK_O,
	input wire logic PLL_LOCK_O,
	input wire logic MIC_CLOCK_OUT_O,
	input wire logic CONV_FRAME_O,
	input wire logic ENGINE_FRAME_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	sequence frame_gap_s;
		!CONV_FRAME_O [*8];
	endsequence
	sequence ref_still_s;
		$stable(REFERENCE_CLOCK_PIN_I) [*8];
	endsequence
	conv_gap_a: assert property (CONV_FRAME_O |=> frame_gap_s)
		else $error("conversion strobe repeated early");
	conv_tick_a: assert property (CONV_FRAME_O |-> $past(CORE_TICK_O))
		else $error("conversion strobe without tick");
	eng_tick_a: assert property (ENGINE_FRAME_O |-> $past(CORE_TICK_O))
		else $error("engine strobe without tick");
	tick_pulse_a: assert property (CORE_TICK_O |=> !CORE_TICK_O)
		else $error("core tick longer than one cycle");
	mic_rise_a: assert property ($rose(MIC_CLOCK_OUT_O) |-> CORE_TICK_O)
		else $error("mic clock rose without tick");
	rdata_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
		else $error("read data changed without read");
	lock_late_a: assert property ($rose(PLL_LOCK_O) |-> !$past(PLL_LOCK_O, 12))
		else $error("lock came too fast");
	lock_lost_a: assert property (ref_still_s |=> !PLL_LOCK_O)
		else $error("lock held with reference stopped");
endmodule : fcs_clock_setup_sva
bind fcs_clock_setup fcs_clock_setup_sva #(.LOCK_REF_EDGES(LOCK_REF_EDGES)) i_sva (
	.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .REFERENCE_CLOCK_PIN_I(REFERENCE_CLOCK_PIN_I),
	.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .CORE_TICK_O(CORE_TICK_O),
	.PLL_LOCK_O(PLL_LOCK_O), .MIC_CLOCK_OUT_O(MIC_CLOCK_OUT_O),
	.CONV_FRAME_O(CONV_FRAME_O), .ENGINE_FRAME_O(ENGINE_FRAME_O));
`default_nettype wire

// file: bench/fcs_ref_src.sv
// reference clock source for the master clock pin
`timescale 1ns/1ps
`default_nettype none
module fcs_ref_src (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic slow_i,
	output logic ref_o
);
	logic [1:0] ph;
	initial ph = 2'h0;
	initial ref_o = 1'b0;
	// 20 MHz, or 13.3 MHz when slow so the pll lands in 41-54 MHz; low while stopped
	always @(posedge clk_i) begin
		if (!run_i) begin
			ph <= 2'h0;
		end else if (ph == (slow_i ? 2'h2 : 2'h1)) begin
			ph <= 2'h0;
		end else begin
			ph <= ph + 2'h1;
		end
		ref_o <= run_i && (ph == 2'h0);
	end
endmodule : fcs_ref_src
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the clock setup block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic run = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, stop = 1'b0, mic_d = 1'b0, slow = 1'b0;
	logic ref_clk, tick, lock, mic, conv, eng, ser;
	logic [7:0] rdata;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int flen [7] = '{256, 1536, 1024, 768, 512, 384, 128};
	initial begin
		forever #12.5 clk = !clk;
	end
	fcs_ref_src i_src (.clk_i(clk), .run_i(run), .slow_i(slow), .ref_o(ref_clk));
	fcs_clock_setup #(.LOCK_REF_EDGES(8)) i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b),
		.REFERENCE_CLOCK_PIN_I(ref_clk), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_STOP_I(stop), .REG_RDATA_O(rdata),
		.CORE_TICK_O(tick), .PLL_LOCK_O(lock), .MIC_CLOCK_OUT_O(mic),
		.CONV_FRAME_O(conv), .ENGINE_FRAME_O(eng), .SERIAL_FRAME_O(ser));
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_b
	task automatic rd_b(input logic [15:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk($sformatf("reg_%h", a), 32'(exp), 32'(rdata));
	endtask : rd_b
	function automatic logic pick(input int w);
		return w == 0 ? conv : w == 1 ? eng : w == 2 ? ser : w == 3 ? (mic & !mic_d) : tick;
	endfunction : pick
	// skips to one event, then counts cycles to the next
	task automatic gap(input int w, input int exp);
		int t;
		t = 0;
		while (!pick(w) && t < 9000) begin
			@(posedge clk);
			t++;
		end
		t = 1;
		@(posedge clk);
		while (!pick(w) && t < 9000) begin
			@(posedge clk);
			t++;
		end
		chk($sformatf("gap_%0d", w), 32'(exp), 32'(t));
	endtask : gap
	task automatic pll_set(input logic [47:0] v);
		int t;
		t = 0;
		for (int i = 0; i < 6; i++) wr_b(16'h4002 + 16'(i), v[8*i +: 8]);
		while (lock !== 1'b1 && t < 400) begin
			@(posedge clk);
			t++;
		end
		chk("lock", 32'h0000_0001, 32'(lock));
	endtask : pll_set
	always @(posedge clk) begin
		mic_d <= mic;
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		run <= 1'b1;
		@(posedge clk);
		rd_b(16'h4000, 8'h00);
		rd_b(16'h4001, 8'h00);
		wr_b(16'h4000, 8'h01);
		for (int c = 0; c < 7; c++) begin
			wr_b(16'h4017, 8'(c));
			gap(0, 2 * flen[c]);
		end
		rd_b(16'h4017, 8'h06);
		wr_b(16'h40eb, 8'h06);
		wr_b(16'h40f8, 8'h05);
		gap(1, 256);
		gap(2, 768);
		gap(3, 8);
		$display("test direct rates done");
		wr_b(16'h4000, 8'h13);
		gap(3, 8);
		gap(1, 512);
		wr_b(16'h4000, 8'h05);
		gap(4, 6);
		wr_b(16'h4000, 8'h07);
		wr_b(16'h40eb, 8'h0f);
		gap(1, 2048);
		gap(3, 32);
		$display("test divider done");
		slow <= 1'b1;
		pll_set(48'h0120_000c_007d);
		rd_b(16'h4007, 8'h03);
		wr_b(16'h4000, 8'h09);
		gap(0, 384);
		gap(4, 3);
		for (int i = 0; i < 4; i++) wr_b(16'h4002 + 16'(i), 8'hff);
		stop <= 1'b1;
		@(posedge clk);
		stop <= 1'b0;
		rd_b(16'h4002, 8'h7d);
		rd_b(16'h4007, 8'h03);
		pll_set(48'h0142_000c_007d);
		gap(0, 384);
		wr_b(16'h4017, 8'h05);
		pll_set(48'h0119_0001_0005);
		gap(0, 1440);
		$display("test pll done");
		run <= 1'b0;
		repeat (12) @(posedge clk);
		chk("lock_lost", 32'h0000_0000, 32'(lock));
		rd_b(16'h4007, 8'h01);
		$display("test lock loss done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
